//--- core/sfp_dev.sv
/*
  Device end of the serial flash program port: command decoder, shifters,
  bank, program timer and error lock. The flash array sits on the user side:
  it answers mem_rd with mem_rdata on the next cycle and reports erase_done.
*/
`timescale 1ns/1ps
`include "sfp_consts.svh"
module sfp_dev
  import sfp_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  sfp_if.dev link,
  output logic [16:0] mem_addr,
  output logic mem_rd,
  input wire logic [7:0] mem_rdata,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  output logic erase_req,
  input wire logic erase_done,
  output logic mode_active,
  output logic cmd_error
);
  // Pin order: vpp, oe_n, sda, sclk
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic sclk_prev_q;
  logic oe_prev_q;
  logic sclk_rise;
  logic sclk_fall;
  logic oe_fall;
  logic oe_rise;
  logic mode_q;
  sfp_dev_st_t st_q;
  logic [2:0] bit_q;
  logic [7:0] rx_q;
  logic [7:0] rx_byte;
  logic rx_state;
  logic byte_done;
  logic send_done;
  logic [7:0] tx_q;
  logic sda_o_q;
  logic sda_oe_q;
  logic bank_q;
  logic [15:0] addr_q;
  logic is_prog_q;
  logic is_verify_q;
  logic is_errchk_q;
  logic [16:0] last_prog_q;
  logic rd_pend_q;
  logic [9:0] prog_cnt_q;
  logic err_q;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_q <= 4'hF;
      sync2_q <= 4'hF;
      sclk_prev_q <= 1'b1;
      oe_prev_q <= 1'b1;
    end
    else
    begin
      sync1_q <= {link.vpp_high, link.oe_n, link.sda, link.sclk};
      sync2_q <= sync1_q;
      sclk_prev_q <= sync2_q[0];
      oe_prev_q <= sync2_q[2];
    end
  end

  assign sclk_rise = mode_q && sync2_q[0] && !sclk_prev_q;
  assign sclk_fall = mode_q && !sync2_q[0] && sclk_prev_q;
  assign oe_fall = !sync2_q[2] && oe_prev_q;
  assign oe_rise = sync2_q[2] && !oe_prev_q;

  // Mode is entered only while data, clock and strobe idle high
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      mode_q <= 1'b0;
    else if (!sync2_q[3])
      mode_q <= 1'b0;
    else if (sync2_q[2:0] == 3'h7)
      mode_q <= 1'b1;
  end

  assign rx_state = (st_q == SFP_D_CMD) || (st_q == SFP_D_ADDR_L) || (st_q == SFP_D_ADDR_H) ||
                    (st_q == SFP_D_DATA) || (st_q == SFP_D_ERASE2);
  assign rx_byte = {sync2_q[1], rx_q[7:1]};
  assign byte_done = rx_state && sclk_rise && (bit_q == `SFP_LAST_BIT);
  assign send_done = (st_q == SFP_D_SEND) && sclk_rise && (bit_q == `SFP_LAST_BIT);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bit_q <= 3'h0;
      rx_q <= 8'h00;
    end
    else if (!mode_q || !(rx_state || st_q == SFP_D_SEND))
      bit_q <= 3'h0;
    else if (sclk_rise)
    begin
      bit_q <= bit_q + 3'h1;
      if (rx_state)
        rx_q <= rx_byte;
    end
  end

  // Command sequencing; an unknown code parks the port until mode exit
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      st_q <= SFP_D_CMD;
    else if (!mode_q)
      st_q <= SFP_D_CMD;
    else
    begin
      unique case (st_q)
        SFP_D_CMD:
          if (byte_done)
          begin
            unique case (rx_byte)
              `SFP_CMD_BANK0, `SFP_CMD_BANK1: st_q <= SFP_D_CMD;
              `SFP_CMD_READ, `SFP_CMD_PROG: st_q <= SFP_D_ADDR_L;
              `SFP_CMD_VERIFY: st_q <= SFP_D_STROBE;
              `SFP_CMD_ERASE: st_q <= SFP_D_ERASE2;
              `SFP_CMD_ERRCHK: st_q <= SFP_D_SEND;
              default: st_q <= SFP_D_LOCKED;
            endcase
          end
        SFP_D_ADDR_L:
          if (byte_done)
            st_q <= SFP_D_ADDR_H;
        SFP_D_ADDR_H:
          if (byte_done)
            st_q <= is_prog_q ? SFP_D_DATA : SFP_D_STROBE;
        SFP_D_DATA:
          if (byte_done)
            st_q <= SFP_D_CMD;
        SFP_D_ERASE2:
          if (byte_done)
            st_q <= (rx_byte == `SFP_CMD_ERASE) ? SFP_D_CMD : SFP_D_LOCKED;
        SFP_D_STROBE:
          if (oe_rise && !rd_pend_q)
            st_q <= SFP_D_SEND;
        SFP_D_SEND:
          if (send_done)
            st_q <= SFP_D_CMD;
        SFP_D_LOCKED:
          st_q <= SFP_D_LOCKED;
        default:
          st_q <= SFP_D_LOCKED;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      is_prog_q <= 1'b0;
      is_verify_q <= 1'b0;
      is_errchk_q <= 1'b0;
    end
    else if (st_q == SFP_D_CMD && byte_done)
    begin
      is_prog_q <= rx_byte == `SFP_CMD_PROG;
      is_verify_q <= rx_byte == `SFP_CMD_VERIFY;
      is_errchk_q <= rx_byte == `SFP_CMD_ERRCHK;
    end
  end

  // Bank returns to 0 whenever the mode is left
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      bank_q <= `SFP_BANK_RESET;
    else if (!mode_q)
      bank_q <= `SFP_BANK_RESET;
    else if (st_q == SFP_D_CMD && byte_done && (rx_byte == `SFP_CMD_BANK0 || rx_byte == `SFP_CMD_BANK1))
      bank_q <= rx_byte[0];
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      addr_q <= 16'h0000;
      last_prog_q <= 17'h00000;
      mem_addr <= 17'h00000;
      mem_wdata <= 8'h00;
      mem_wr <= 1'b0;
      mem_rd <= 1'b0;
      rd_pend_q <= 1'b0;
    end
    else
    begin
      mem_wr <= 1'b0;
      mem_rd <= 1'b0;
      rd_pend_q <= mem_rd;
      if (st_q == SFP_D_ADDR_L && byte_done)
        addr_q[7:0] <= rx_byte;
      if (st_q == SFP_D_ADDR_H && byte_done)
        addr_q[15:8] <= rx_byte;
      if (st_q == SFP_D_DATA && byte_done)
      begin
        mem_addr <= {bank_q, addr_q};
        last_prog_q <= {bank_q, addr_q};
        mem_wdata <= rx_byte;
        mem_wr <= 1'b1;
      end
      if (st_q == SFP_D_STROBE && oe_fall)
      begin
        mem_addr <= is_verify_q ? last_prog_q : {bank_q, addr_q};
        mem_rd <= 1'b1;
      end
    end
  end

  // Output shifter: a bit goes out on each falling clock edge
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_q <= 8'h00;
      sda_o_q <= 1'b1;
      sda_oe_q <= 1'b0;
    end
    else if (!mode_q)
      sda_oe_q <= 1'b0;
    else
    begin
      if (rd_pend_q)
        tx_q <= mem_rdata;
      if (st_q == SFP_D_CMD && byte_done && rx_byte == `SFP_CMD_ERRCHK)
      begin
        tx_q <= 8'h00;
        tx_q[`SFP_ERR_BIT] <= err_q;
      end
      if (st_q == SFP_D_SEND && sclk_fall)
      begin
        sda_o_q <= tx_q[0];
        tx_q <= {1'b0, tx_q[7:1]};
        sda_oe_q <= 1'b1;
      end
      if (send_done)
        sda_oe_q <= 1'b0;
    end
  end

  // A new invalid code wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      err_q <= 1'b0;
    else if (mode_q && byte_done && st_q == SFP_D_CMD && rx_byte != `SFP_CMD_BANK0 &&
             rx_byte != `SFP_CMD_BANK1 && rx_byte != `SFP_CMD_READ && rx_byte != `SFP_CMD_PROG &&
             rx_byte != `SFP_CMD_VERIFY && rx_byte != `SFP_CMD_ERASE && rx_byte != `SFP_CMD_ERRCHK)
      err_q <= 1'b1;
    else if (mode_q && byte_done && st_q == SFP_D_ERASE2 && rx_byte != `SFP_CMD_ERASE)
      err_q <= 1'b1;
    else if (send_done && is_errchk_q)
      err_q <= 1'b0;
  end

  // Program timer and erase request drive busy
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prog_cnt_q <= 10'h000;
      erase_req <= 1'b0;
    end
    else
    begin
      if (st_q == SFP_D_DATA && byte_done)
        prog_cnt_q <= `SFP_PROG_CYC;
      else if (prog_cnt_q != 10'h000)
        prog_cnt_q <= prog_cnt_q - 10'h001;
      if (st_q == SFP_D_ERASE2 && byte_done && rx_byte == `SFP_CMD_ERASE)
        erase_req <= 1'b1;
      else if (erase_done)
        erase_req <= 1'b0;
    end
  end

  assign link.busy = (prog_cnt_q != 10'h000) || erase_req;
  assign link.sda_dev_o = sda_o_q;
  assign link.sda_dev_oe = sda_oe_q;
  assign mode_active = mode_q;
  assign cmd_error = err_q;
endmodule : sfp_dev

//--- core/sfp_consts.svh
/*
  Constants of the serial flash program port: command codes, bit counts and
  timing counts. Assumes a 100 MHz system clock on both ends.
*/
// Overview of operation
// - Programmer enters mode with pins high, then supply
// - All transfers shift least significant bit first
// - Device samples input data on serial clock rise
// - Device changes output data on serial clock fall
// - Each transfer is exactly eight serial clocks
// - First transfer is command; others follow command order
// - Codes E0/E1 choose bank, bank is address bit 16
// - Bank stays until the next bank select
// - Bank 0 selected on mode entry
// - Bank ignored by auto erase and error check
// - Read: code, low address, high address, strobe
// - Strobe low fetches byte; then shifted out
// - Program: code, low address, high address, data
// - Program starts last rise; busy at most 10 us
// - Programmer verifies after program, repeats on failure
// - Verify re-reads last programmed address on strobe
// - Two erase codes start erase; busy until done
// - Error check shifts out error byte, flag bit 0
// - Invalid command locks port until mode re-entry
`ifndef SFP_CONSTS_SVH
`define SFP_CONSTS_SVH
`define SFP_CMD_BANK0 8'hE0
`define SFP_CMD_BANK1 8'hE1
`define SFP_CMD_READ 8'h00
`define SFP_CMD_PROG 8'h40
`define SFP_CMD_VERIFY 8'hC0
`define SFP_CMD_ERASE 8'h30
`define SFP_CMD_ERRCHK 8'h80
`define SFP_LAST_BIT 3'h7
`define SFP_ERR_BIT 0
`define SFP_BANK_RESET 1'b0
`define SFP_CLK_MHZ 100
`define SFP_CLK_NS 10
`define SFP_PROG_TIME_US 10
`define SFP_PROG_CYC 10'((`SFP_PROG_TIME_US * `SFP_CLK_MHZ))
`define SFP_SCLK_HALF_NS 150
`define SFP_SCLK_HALF_CYC 8'((`SFP_SCLK_HALF_NS + `SFP_CLK_NS - 1) / `SFP_CLK_NS)
`define SFP_GAP_NS 400
`define SFP_GAP_CYC 8'((`SFP_GAP_NS + `SFP_CLK_NS - 1) / `SFP_CLK_NS)
`define SFP_STROBE_NS 320
`define SFP_STROBE_CYC 8'((`SFP_STROBE_NS + `SFP_CLK_NS - 1) / `SFP_CLK_NS)
`define SFP_VPP_SETUP_US 1
`define SFP_VPP_SETUP_CYC 8'((`SFP_VPP_SETUP_US * `SFP_CLK_MHZ))
`define SFP_FIFO_WIDTH 10
`define SFP_FIFO_DEPTH 16
`endif

//--- core/sfp_pkg.sv
/*
  Types shared by both ends of the serial flash program port.
  Assumes sfp_consts.svh for the numeric constants.
*/
package sfp_pkg;
  typedef enum logic [7:0] {
    SFP_D_CMD = 8'h01,
    SFP_D_ADDR_L = 8'h02,
    SFP_D_ADDR_H = 8'h04,
    SFP_D_DATA = 8'h08,
    SFP_D_ERASE2 = 8'h10,
    SFP_D_STROBE = 8'h20,
    SFP_D_SEND = 8'h40,
    SFP_D_LOCKED = 8'h80
  } sfp_dev_st_t;
  typedef enum logic [5:0] {
    SFP_P_OFF = 6'h01,
    SFP_P_VPP = 6'h02,
    SFP_P_IDLE = 6'h04,
    SFP_P_SHIFT = 6'h08,
    SFP_P_STROBE = 6'h10,
    SFP_P_WAIT = 6'h20
  } sfp_prog_st_t;
  typedef enum logic [1:0] {
    SFP_OP_SEND = 2'h0,
    SFP_OP_RECV = 2'h1,
    SFP_OP_STROBE = 2'h2,
    SFP_OP_BUSY = 2'h3
  } sfp_op_t;
endpackage : sfp_pkg

//--- core/sfp_if.sv
/*
  Link between the programmer and the device end.
  The shared data pin is resolved here from both drivers; a pull-up holds it
  high when nobody drives.
*/
`timescale 1ns/1ps
interface sfp_if;
  logic sclk;
  logic sda;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic sda_prog_o;
  logic sda_prog_oe;
  logic oe_n;
  logic busy;
  logic vpp_high;
  assign sda = sda_dev_oe ? sda_dev_o : (sda_prog_oe ? sda_prog_o : 1'b1);
  modport dev (input sclk, input sda, input oe_n, input vpp_high, output sda_dev_o, output sda_dev_oe, output busy);
  modport prog (output sclk, output sda_prog_o, output sda_prog_oe, output oe_n, output vpp_high,
                input sda, input busy);
endinterface : sfp_if

//--- core/sfp_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock; depth is a power of two.
*/
`timescale 1ns/1ps
`include "sfp_consts.svh"
module sfp_fifo #(
  parameter int WIDTH = `SFP_FIFO_WIDTH,
  parameter int DEPTH = `SFP_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data = mem[rd_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_q[AW-1:0]] <= in_data;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
    end
  end
endmodule : sfp_fifo

//--- core/sfp_prog.sv
/*
  Programmer end: takes operations from a 16-word FIFO and plays them on the
  link, making the serial clock by a divider. Assumes the user side queues
  whole command sequences (send, receive, strobe, wait-for-busy).
*/
`timescale 1ns/1ps
`include "sfp_consts.svh"
module sfp_prog
  import sfp_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  sfp_if.prog link,
  input wire logic enter_mode,
  input wire logic op_valid,
  output logic op_ready,
  input wire logic [1:0] op_code,
  input wire logic [7:0] op_data,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic in_mode
);
  logic f_valid;
  logic f_ready;
  logic [`SFP_FIFO_WIDTH-1:0] f_data;
  sfp_prog_st_t st_q;
  logic [7:0] cnt_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic recv_q;
  logic gap_q;
  logic sclk_q;
  logic sda_oe_q;
  logic oe_n_q;
  logic vpp_q;
  logic [1:0] sda_s_q;
  logic [1:0] busy_s_q;

  sfp_fifo #(.WIDTH(`SFP_FIFO_WIDTH), .DEPTH(`SFP_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(op_valid),
    .in_ready(op_ready),
    .in_data({op_code, op_data}),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  assign f_ready = st_q == SFP_P_IDLE && enter_mode;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sda_s_q <= 2'h3;
      busy_s_q <= 2'h0;
    end
    else
    begin
      sda_s_q <= {sda_s_q[0], link.sda};
      busy_s_q <= {busy_s_q[0], link.busy};
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= SFP_P_OFF;
      cnt_q <= 8'h00;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      recv_q <= 1'b0;
      gap_q <= 1'b0;
      sclk_q <= 1'b1;
      sda_oe_q <= 1'b0;
      oe_n_q <= 1'b1;
      vpp_q <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
    end
    else
    begin
      rx_valid <= 1'b0;
      if (!enter_mode)
      begin
        st_q <= SFP_P_OFF;
        vpp_q <= 1'b0;
        sclk_q <= 1'b1;
        sda_oe_q <= 1'b0;
        oe_n_q <= 1'b1;
      end
      else
      begin
        unique case (st_q)
          SFP_P_OFF:
          begin
            cnt_q <= `SFP_VPP_SETUP_CYC;
            st_q <= SFP_P_VPP;
          end
          SFP_P_VPP:
            if (cnt_q != 8'h00)
              cnt_q <= cnt_q - 8'h01;
            else
            begin
              vpp_q <= 1'b1;
              st_q <= SFP_P_IDLE;
            end
          SFP_P_IDLE:
            if (f_valid)
            begin
              sh_q <= f_data[7:0];
              bit_q <= 3'h0;
              gap_q <= 1'b0;
              recv_q <= f_data[9:8] == SFP_OP_RECV;
              cnt_q <= `SFP_SCLK_HALF_CYC;
              unique case (sfp_op_t'(f_data[9:8]))
                SFP_OP_SEND, SFP_OP_RECV: st_q <= SFP_P_SHIFT;
                SFP_OP_STROBE:
                begin
                  oe_n_q <= 1'b0;
                  cnt_q <= `SFP_STROBE_CYC;
                  st_q <= SFP_P_STROBE;
                end
                SFP_OP_BUSY: st_q <= SFP_P_WAIT;
              endcase
            end
          SFP_P_SHIFT:
            if (cnt_q != 8'h00)
              cnt_q <= cnt_q - 8'h01;
            else if (gap_q)
            begin
              // Release only after the gap, so the last bit still stands when the far end samples the rise
              sda_oe_q <= 1'b0;
              st_q <= SFP_P_IDLE;
              rx_valid <= recv_q;
              rx_data <= sh_q;
            end
            else if (sclk_q)
            begin
              sclk_q <= 1'b0;
              cnt_q <= `SFP_SCLK_HALF_CYC;
              if (!recv_q)
              begin
                sda_oe_q <= 1'b1;
                sh_q <= {1'b0, sh_q[7:1]};
              end
            end
            else
            begin
              sclk_q <= 1'b1;
              cnt_q <= `SFP_SCLK_HALF_CYC;
              bit_q <= bit_q + 3'h1;
              if (recv_q)
                sh_q <= {sda_s_q[1], sh_q[7:1]};
              if (bit_q == `SFP_LAST_BIT)
              begin
                gap_q <= 1'b1;
                cnt_q <= `SFP_GAP_CYC;
              end
            end
          SFP_P_STROBE:
            if (cnt_q != 8'h00)
              cnt_q <= cnt_q - 8'h01;
            else if (!oe_n_q)
            begin
              oe_n_q <= 1'b1;
              cnt_q <= `SFP_GAP_CYC;
            end
            else
              st_q <= SFP_P_IDLE;
          SFP_P_WAIT:
            if (!busy_s_q[1])
              st_q <= SFP_P_IDLE;
        endcase
      end
    end
  end

  // Data bit is set up at the falling edge, from the low bit of the shifter
  logic sda_bit_q;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      sda_bit_q <= 1'b1;
    else if (st_q == SFP_P_SHIFT && !gap_q && sclk_q && cnt_q == 8'h00)
      sda_bit_q <= sh_q[0];
  end

  assign link.sclk = sclk_q;
  assign link.sda_prog_o = sda_bit_q;
  assign link.sda_prog_oe = sda_oe_q;
  assign link.oe_n = oe_n_q;
  assign link.vpp_high = vpp_q;
  assign in_mode = vpp_q;
endmodule : sfp_prog

//--- tb/sfp_link_assertions.sv
/*
  Checker for the link between programmer and device ends: drive windows, bit timing and busy.
  Assumes every link signal is sampled on the one system clock.
*/
`timescale 1ns/1ps
module sfp_link_assertions (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic sda_prog_oe,
  input wire logic oe_n,
  input wire logic busy,
  input wire logic vpp_high
);
  localparam int PROG_MAX = 1000;
  logic sclk_q;
  logic oe_q;
  logic [3:0] rise_cnt_q;
  logic [10:0] busy_cnt_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      sclk_q <= 1'b1;
    else
      sclk_q <= sclk;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      oe_q <= 1'b0;
    else
      oe_q <= sda_dev_oe;
  // Rises seen while the device drives; held after release so the count can be judged
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      rise_cnt_q <= 4'h0;
    else if (sda_dev_oe && !oe_q)
      rise_cnt_q <= 4'h0;
    else if (sda_dev_oe && sclk && !sclk_q)
      rise_cnt_q <= rise_cnt_q + 4'h1;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      busy_cnt_q <= 11'h000;
    else if (busy && busy_cnt_q != 11'h7FF)
      busy_cnt_q <= busy_cnt_q + 11'h001;
    else if (!busy)
      busy_cnt_q <= 11'h000;
  sequence s_supply_gone;
    !vpp_high [*4];
  endsequence
  sequence s_busy_begin;
    !busy ##1 busy;
  endsequence
  property p_no_contention; !(sda_dev_oe && sda_prog_oe); endproperty
  property p_drive_starts_low; $rose(sda_dev_oe) |-> !sclk; endproperty
  property p_stable_while_high; (sclk && $past(sclk) && sda_dev_oe && oe_q) |-> $stable(sda_dev_o); endproperty
  property p_eight_rises; $fell(sda_dev_oe) |-> rise_cnt_q == 4'h8 && sclk; endproperty
  property p_busy_bound; busy_cnt_q <= PROG_MAX; endproperty
  property p_busy_start; s_busy_begin |-> sclk && !sda_dev_oe; endproperty
  property p_fall_no_busy; $fell(sclk) |-> !busy; endproperty
  property p_quiet_outside; s_supply_gone |-> !sda_dev_oe && !busy; endproperty
  property p_strobe_no_drive; !oe_n |-> !sda_dev_oe; endproperty
  a_no_contention: assert property (p_no_contention)
    else $error("both ends drive the data pin");
  a_drive_starts_low: assert property (p_drive_starts_low)
    else $error("device drive began outside a low clock phase");
  a_stable_while_high: assert property (p_stable_while_high)
    else $error("device data changed while serial clock high");
  a_eight_rises: assert property (p_eight_rises)
    else $error("device byte not eight clocks long");
  a_busy_bound: assert property (p_busy_bound)
    else $error("busy held longer than the program time");
  a_busy_start: assert property (p_busy_start)
    else $error("busy rose away from a final rising clock");
  a_fall_no_busy: assert property (p_fall_no_busy)
    else $error("busy high during a transfer");
  a_quiet_outside: assert property (p_quiet_outside)
    else $error("device active outside serial mode");
  a_strobe_no_drive: assert property (p_strobe_no_drive)
    else $error("device drives data during the read strobe");
endmodule : sfp_link_assertions

//--- tb/serial_flash_program_port_bench.sv
/*
  Self-checking bench: both ends joined by the link, a stand-in flash on the device user side and
  a reference model of its contents. Assumes inputs change on falling clock edges.
*/
`timescale 1ns/1ps
`include "sfp_consts.svh"
module serial_flash_program_port_bench;
  import sfp_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic enter_mode = 1'b0;
  logic op_valid = 1'b0;
  logic [1:0] op_code = 2'h0;
  logic [7:0] op_data = 8'h00;
  logic [7:0] mem_rdata = 8'h00;
  logic erase_done = 1'b0;
  logic op_ready, rx_valid, in_mode, mem_rd, mem_wr, erase_req, mode_active, cmd_error, sclk_prev;
  logic [7:0] rx_data, mem_wdata, sniff, d;
  logic [16:0] mem_addr, last_a;
  logic [15:0] a;
  logic bank_q = 1'b0;
  int fail_count = 0;
  int cmp_count = 0;
  int seed = 32'h4e13819b;
  int sniff_n = 0;
  int erase_cnt = 0;
  logic [7:0] model [int];
  logic [7:0] flash [int];
  logic [7:0] exp_rx [$];
  logic [7:0] exp_wire [$];
  logic [24:0] exp_wr [$];
  logic [16:0] exp_rd [$];
  sfp_if link ();
  sfp_dev sfp_dev_i (.clk(clk), .rstn(rstn), .link(link.dev), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .erase_req(erase_req),
    .erase_done(erase_done), .mode_active(mode_active), .cmd_error(cmd_error));
  sfp_prog sfp_prog_i (.clk(clk), .rstn(rstn), .link(link.prog), .enter_mode(enter_mode), .op_valid(op_valid),
    .op_ready(op_ready), .op_code(op_code), .op_data(op_data), .rx_valid(rx_valid), .rx_data(rx_data),
    .in_mode(in_mode));
  sfp_link_assertions sfp_link_assertions_i (.clk(clk), .rstn(rstn), .sclk(link.sclk), .sda_dev_o(link.sda_dev_o),
    .sda_dev_oe(link.sda_dev_oe), .sda_prog_oe(link.sda_prog_oe), .oe_n(link.oe_n), .busy(link.busy),
    .vpp_high(link.vpp_high));
  always #5 clk = ~clk;

  task automatic check(input string what, input logic [31:0] exp_v, input logic [31:0] got);
    cmp_count++;
    if (got !== exp_v)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp_v, got);
    end
  endtask : check

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  function automatic logic [7:0] rd_model(input logic [16:0] adr);
    return model.exists(adr) ? model[adr] : 8'hFF;
  endfunction : rd_model

  task automatic push(input logic [1:0] c, input logic [7:0] v);
    @(negedge clk);
    while (op_ready !== 1'b1) @(negedge clk);
    op_valid = 1'b1;
    op_code = c;
    op_data = v;
    @(negedge clk);
    op_valid = 1'b0;
  endtask : push

  task automatic send(input logic [7:0] v);
    push(SFP_OP_SEND, v);
    exp_wire.push_back(v);
  endtask : send

  task automatic recv(input logic [7:0] e);
    push(SFP_OP_RECV, 8'h00);
    exp_wire.push_back(e);
    exp_rx.push_back(e);
  endtask : recv

  task automatic err_chk(input logic [7:0] e);
    send(`SFP_CMD_ERRCHK);
    recv(e);
  endtask : err_chk

  task automatic sel_bank(input logic b);
    send(b ? `SFP_CMD_BANK1 : `SFP_CMD_BANK0);
    bank_q = b;
  endtask : sel_bank

  // Program then wait for busy low, as the far side must before its next command
  task automatic prog(input logic [15:0] adr, input logic [7:0] v);
    send(`SFP_CMD_PROG);
    send(adr[7:0]);
    send(adr[15:8]);
    send(v);
    push(SFP_OP_BUSY, 8'h00);
    last_a = {bank_q, adr};
    model[last_a] = v;
    exp_wr.push_back({last_a, v});
  endtask : prog

  task automatic verify();
    send(`SFP_CMD_VERIFY);
    push(SFP_OP_STROBE, 8'h00);
    exp_rd.push_back(last_a);
    recv(rd_model(last_a));
  endtask : verify

  task automatic read(input logic [15:0] adr);
    send(`SFP_CMD_READ);
    send(adr[7:0]);
    send(adr[15:8]);
    push(SFP_OP_STROBE, 8'h00);
    exp_rd.push_back({bank_q, adr});
    recv(rd_model({bank_q, adr}));
  endtask : read

  task automatic settle(input string name);
    for (int i = 0; i < 20000 && exp_wire.size() > 0; i++) @(negedge clk);
    repeat (80) @(negedge clk);
    check("pending bytes", 0, exp_wire.size() + exp_rx.size() + exp_wr.size() + exp_rd.size());
    check("busy after test", 0, link.busy);
    check("in mode", 1, in_mode);
    $display("test %s done", name);
  endtask : settle

  // Stand-in flash, wire sniffer and result monitor, all on settled values
  always @(negedge clk)
  begin
    if (link.sclk === 1'b1 && sclk_prev === 1'b0 && in_mode === 1'b1)
    begin
      sniff = {link.sda, sniff[7:1]};
      sniff_n++;
      if (sniff_n == 8)
        check("wire byte", exp_wire.size() ? exp_wire.pop_front() : 9'h1FF, sniff);
      if (sniff_n == 8)
        sniff_n = 0;
    end
    sclk_prev = link.sclk;
    if (rx_valid === 1'b1)
      check("rx_data", exp_rx.size() ? exp_rx.pop_front() : 9'h1FF, rx_data);
    if (mem_wr === 1'b1)
      check("write", exp_wr.size() ? exp_wr.pop_front() : 26'h3FFFFFF, {mem_addr, mem_wdata});
    if (mem_wr === 1'b1)
      flash[mem_addr] = mem_wdata;
    if (mem_rd === 1'b1)
      check("read address", exp_rd.size() ? exp_rd.pop_front() : 18'h3FFFF, mem_addr);
    if (mem_rd === 1'b1)
      mem_rdata = flash.exists(mem_addr) ? flash[mem_addr] : 8'hFF;
    erase_cnt = (erase_req === 1'b1) ? erase_cnt + 1 : 0;
    erase_done = (erase_cnt == 200);
    if (erase_cnt == 200)
      flash.delete();
  end

  initial
  begin
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    // Queue is filled while the supply is off, so nothing drains it
    err_chk(8'h00);
    sel_bank(1'b1);
    prog(16'hFFFF, 8'h5A);
    verify();
    read(16'hFFFF);
    check("queue full", 0, op_ready);
    enter_mode = 1'b1;
    settle("full queue, top address");
    for (int i = 0; i < 4; i++)
    begin
      a = 16'($random(seed));
      d = 8'($random(seed));
      sel_bank(i[0]);
      prog(a, d);
      verify();
      read(a ^ 16'h0001);
      read(a);
    end
    settle("random program and read");
    send(`SFP_CMD_ERASE);
    send(`SFP_CMD_ERASE);
    push(SFP_OP_BUSY, 8'h00);
    model.delete();
    read(a);
    settle("auto erase");
    send(8'h55);
    err_chk(8'hFF);
    settle("invalid command");
    check("error flag", 1, cmd_error);
    enter_mode = 1'b0;
    for (int i = 0; i < 1000 && mode_active !== 1'b0; i++) @(negedge clk);
    check("mode left", 0, mode_active);
    enter_mode = 1'b1;
    err_chk(8'h01);
    err_chk(8'h00);
    bank_q = 1'b0;
    read(16'h0000);
    settle("mode re-entry");
    report_and_stop();
  end

  initial
  begin
    repeat (90000) @(negedge clk);
    fail_count++;
    $display("unexpected run length: expected end of tests, seen none");
    report_and_stop();
  end
endmodule : serial_flash_program_port_bench
